//--- hdl/output_delay_and_status_regs.vh
// register offsets, field positions, reset values and timing constants for the status register bank
// Notes on behaviour
// - fine delay adds code times 254 ps
// - retime divide-by-one uses half oscillator period step
// - analog delay code times 30 ps, reset 000
// - total output delay is fine plus analog
// - ref oscillator output power-down bit, reset 0
// - ref oscillator output format bit, reset 0
// - enable, latched, live status share bit positions
// - latched reads 0 after event, write 1 clears
// - alert reaches interrupt pin only when enabled
// - four-bit function code selects each pin's function
// - polarity bit inverts every status pin output
`ifndef OUTPUT_DELAY_AND_STATUS_REGS_VH
`define OUTPUT_DELAY_AND_STATUS_REGS_VH

`define ADDR_PIN_FUNCTION 8'h88
`define ADDR_PIN_POLARITY 8'h89
`define ADDR_IRQ_ENABLE 8'h8c
`define ADDR_LATCHED_STATUS 8'h90
`define ADDR_LIVE_STATUS 8'h94
`define ADDR_FCV_REF_STATUS 8'h96
`define ADDR_OSC_INIT_STATUS 8'h97
`define ADDR_REF_OSC_CTRL 8'h98
`define ADDR_DELAY_BASE 8'h40
`define NUM_OUTPUTS 12

`define PIN_FUNCTION_RESET 8'hab
`define PIN_POLARITY_RESET 8'h00
`define IRQ_ENABLE_RESET 8'h00
`define LATCHED_RESET 8'hcf
`define STATUS_MASK 8'hcf
`define REF_OSC_CTRL_RESET 8'h00
`define DELAY_CFG_RESET 8'h00
`define DELAY_CFG_MASK 8'h3f
`define MONITOR_SYNC_RESET 10'h03d

`define BIT_IN0_LOSS 7
`define BIT_IN1_LOSS 6
`define BIT_LOOP0_LOCK 3
`define BIT_LOOP1_LOCK 2
`define BIT_HOLDOVER 1
`define BIT_REF_VALID 0
`define BIT_POLARITY 0
`define BIT_REF_OSC_PD 0
`define BIT_REF_OSC_FORMAT 1
`define BIT_FCV 7
`define BIT_SEL_REF_LO 4
`define BIT_OSC_INIT 2
`define FINE_LSB 0
`define ANALOG_LSB 2
`define RETIME_BIT 5

`define FN_LOOP0_LOCK 4'h8
`define FN_LOOP1_LOCK 4'h9
`define FN_BOTH_LOCK 4'ha
`define FN_ACTIVITY_ALARM 4'hb
`define FN_HOLDOVER 4'hc
`define FN_INTERRUPT 4'hd
`define FN_SELECTED_INPUT 4'hf

`define FINE_STEP_PS 16'h00fe
`define ANALOG_STEP_PS 8'h1e
`define DELAY_WIDTH 19

`endif

//--- hdl/output_delay_calc.v
// per-output delay computation from fine and analog codes
`include "output_delay_and_status_regs.vh"
module output_delay_calc (
  // clock and reset
  input wire core_clk_in,
  input wire srst_in,
  // codes
  input wire [1:0] fine_code_in,
  input wire [2:0] analog_delay_code_in,
  input wire retime_divide_by_one_in,
  input wire [15:0] half_period_ps_in,
  // result
  output reg [`DELAY_WIDTH-1:0] delay_ps_out
);
  wire [15:0] fine_step;
  wire [17:0] fine_ps;
  wire [10:0] analog_ps;
  assign fine_step = retime_divide_by_one_in ? half_period_ps_in : `FINE_STEP_PS;
  assign fine_ps = fine_step * fine_code_in;
  assign analog_ps = `ANALOG_STEP_PS * analog_delay_code_in;
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      delay_ps_out <= {`DELAY_WIDTH{1'b0}};
    end else begin
      delay_ps_out <= {1'b0, fine_ps} + {8'h00, analog_ps};
    end
  end
endmodule // output_delay_calc

//--- hdl/output_delay_and_status_regs.v
// status, pin function and output delay register bank
`include "output_delay_and_status_regs.vh"
module output_delay_and_status_regs (
  // clock and reset
  input wire core_clk_in,
  input wire srst_in,
  // register port from the configuration interface
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // asynchronous monitor inputs, 1 = good unless noted
  input wire input0_loss_live_in,
  input wire input1_loss_live_in,
  input wire first_loop_lock_live_in,
  input wire second_loop_lock_live_in,
  input wire first_loop_holdover_live_in,
  input wire first_loop_ref_valid_live_in,
  input wire forced_control_voltage_status_in,
  input wire [1:0] selected_reference_status_in,
  input wire internal_osc_init_status_in,
  // oscillator half period, same clock domain
  input wire [15:0] half_period_ps_in,
  // reference oscillator output control
  output reg ref_osc_out_power_down_out,
  output reg ref_osc_out_format_out,
  // status pins
  output reg [1:0] status_pin_out,
  output reg [1:0] status_pin_oe_out,
  // per-output delay results, output i at bits [19*i +: 19]
  output wire [`NUM_OUTPUTS*`DELAY_WIDTH-1:0] output_delay_ps_out
);
  reg [9:0] sync_a;
  reg [9:0] sync_b;
  reg [7:0] pin_function;
  reg status_pin_polarity;
  reg [7:0] irq_enable;
  reg [7:0] latched;
  reg [1:0] ref_osc_ctrl;
  reg [7:0] delay_cfg [0:`NUM_OUTPUTS-1];
  reg [7:0] next_rdata;
  wire [7:0] live;
  wire [7:0] alert_cond;
  wire irq_pending;
  wire wr_latched;
  wire [7:0] delay_index;
  integer k;

  // true when the address hits one of the delay registers
  function in_delay_range;
    input [7:0] a;
    begin
      in_delay_range = (a >= `ADDR_DELAY_BASE) &&
        (a < `ADDR_DELAY_BASE + `NUM_OUTPUTS);
    end
  endfunction

  // level driven by a status pin for a given function code
  function pin_level;
    input [3:0] code;
    input pin_index;
    input [7:0] st;
    input irq;
    input [1:0] sel;
    begin
      case (code)
        `FN_LOOP0_LOCK: pin_level = st[`BIT_LOOP0_LOCK];
        `FN_LOOP1_LOCK: pin_level = st[`BIT_LOOP1_LOCK];
        `FN_BOTH_LOCK: pin_level = st[`BIT_LOOP0_LOCK] & st[`BIT_LOOP1_LOCK];
        `FN_ACTIVITY_ALARM: pin_level = ~(st[`BIT_IN0_LOSS] & st[`BIT_IN1_LOSS]);
        `FN_HOLDOVER: pin_level = st[`BIT_HOLDOVER];
        `FN_INTERRUPT: pin_level = irq;
        `FN_SELECTED_INPUT: pin_level = pin_index ? 1'b0 : sel[0];
        default: pin_level = 1'b0;
      endcase
    end
  endfunction

  // whether a function code makes the pin an output
  function pin_drives;
    input [3:0] code;
    input pin_index;
    begin
      case (code)
        `FN_LOOP0_LOCK, `FN_LOOP1_LOCK, `FN_BOTH_LOCK, `FN_ACTIVITY_ALARM,
        `FN_HOLDOVER, `FN_INTERRUPT: pin_drives = 1'b1;
        `FN_SELECTED_INPUT: pin_drives = ~pin_index;
        default: pin_drives = 1'b0;
      endcase
    end
  endfunction

  // two-stage synchronisers for the monitor inputs
  // reset to alarm-free levels, so no false alert is latched after reset
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      sync_a <= `MONITOR_SYNC_RESET;
      sync_b <= `MONITOR_SYNC_RESET;
    end else begin
      sync_a <= {internal_osc_init_status_in, selected_reference_status_in,
        forced_control_voltage_status_in, input0_loss_live_in, input1_loss_live_in,
        first_loop_lock_live_in, second_loop_lock_live_in,
        first_loop_holdover_live_in, first_loop_ref_valid_live_in};
      sync_b <= sync_a;
    end
  end

  assign live = {sync_b[5], sync_b[4], 2'b00, sync_b[3], sync_b[2], sync_b[1],
    sync_b[0]};
  // holdover alerts when entered, all others alert when low
  assign alert_cond = {~live[7], ~live[6], 2'b00, ~live[3], ~live[2], live[1], ~live[0]};
  assign wr_latched = reg_wr_in && (reg_addr_in == `ADDR_LATCHED_STATUS);
  assign delay_index = reg_addr_in - `ADDR_DELAY_BASE;
  assign irq_pending = |(~latched & irq_enable & `STATUS_MASK);

  // writable control registers
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      pin_function <= `PIN_FUNCTION_RESET;
      status_pin_polarity <= 1'b0;
      irq_enable <= `IRQ_ENABLE_RESET;
      ref_osc_ctrl <= 2'b00;
      for (k = 0; k < `NUM_OUTPUTS; k = k + 1) begin
        delay_cfg[k] <= `DELAY_CFG_RESET;
      end
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `ADDR_PIN_FUNCTION: pin_function <= reg_wdata_in;
        `ADDR_PIN_POLARITY: status_pin_polarity <= reg_wdata_in[`BIT_POLARITY];
        `ADDR_IRQ_ENABLE: irq_enable <= reg_wdata_in & `STATUS_MASK;
        `ADDR_REF_OSC_CTRL: ref_osc_ctrl <= reg_wdata_in[1:0];
        default: begin
          for (k = 0; k < `NUM_OUTPUTS; k = k + 1) begin
            if (reg_addr_in == `ADDR_DELAY_BASE + k[7:0]) begin
              delay_cfg[k] <= reg_wdata_in & `DELAY_CFG_MASK;
            end
          end
        end
      endcase
    end
  end

  // latched alerts: an event in the clearing cycle wins
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : latch_bit
      if (g == 4 || g == 5) begin : reserved_bit
        always @(posedge core_clk_in) begin
          latched[g] <= 1'b0;
        end
      end else begin : live_bit
        always @(posedge core_clk_in) begin
          if (srst_in) begin
            latched[g] <= 1'b1;
          end else if (alert_cond[g]) begin
            latched[g] <= 1'b0;
          end else if (wr_latched && reg_wdata_in[g]) begin
            latched[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // read data mux
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr_in)
      `ADDR_PIN_FUNCTION: next_rdata = pin_function;
      `ADDR_PIN_POLARITY: next_rdata = {7'h00, status_pin_polarity};
      `ADDR_IRQ_ENABLE: next_rdata = irq_enable;
      `ADDR_LATCHED_STATUS: next_rdata = latched;
      `ADDR_LIVE_STATUS: next_rdata = live;
      `ADDR_FCV_REF_STATUS: next_rdata = {sync_b[6], 1'b0, sync_b[8:7], 4'h0};
      `ADDR_OSC_INIT_STATUS: next_rdata = {5'h00, sync_b[9], 2'b00};
      `ADDR_REF_OSC_CTRL: next_rdata = {6'h00, ref_osc_ctrl};
      default: begin
        if (in_delay_range(reg_addr_in)) begin
          next_rdata = delay_cfg[delay_index[3:0]];
        end
      end
    endcase
  end

  always @(posedge core_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
      ref_osc_out_power_down_out <= 1'b0;
      ref_osc_out_format_out <= 1'b0;
      status_pin_out <= 2'b00;
      status_pin_oe_out <= 2'b00;
    end else begin
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
      ref_osc_out_power_down_out <= ref_osc_ctrl[`BIT_REF_OSC_PD];
      ref_osc_out_format_out <= ref_osc_ctrl[`BIT_REF_OSC_FORMAT];
      status_pin_out[0] <= status_pin_polarity ^
        pin_level(pin_function[3:0], 1'b0, live, irq_pending, sync_b[8:7]);
      status_pin_out[1] <= status_pin_polarity ^
        pin_level(pin_function[7:4], 1'b1, live, irq_pending, sync_b[8:7]);
      status_pin_oe_out[0] <= pin_drives(pin_function[3:0], 1'b0);
      status_pin_oe_out[1] <= pin_drives(pin_function[7:4], 1'b1);
    end
  end

  generate
    for (g = 0; g < `NUM_OUTPUTS; g = g + 1) begin : delay_out
      output_delay_calc u_calc (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .fine_code_in(delay_cfg[g][`FINE_LSB +: 2]),
        .analog_delay_code_in(delay_cfg[g][`ANALOG_LSB +: 3]),
        .retime_divide_by_one_in(delay_cfg[g][`RETIME_BIT]),
        .half_period_ps_in(half_period_ps_in),
        .delay_ps_out(output_delay_ps_out[g*`DELAY_WIDTH +: `DELAY_WIDTH])
      );
    end
  endgenerate
endmodule // output_delay_and_status_regs

//--- verif/regs_checker_assertions.sv
// concurrent checks on the register port of the status and delay bank
`include "output_delay_and_status_regs.vh"
module regs_checker (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // reference oscillator output control
  input wire logic ref_osc_out_power_down_out,
  input wire logic ref_osc_out_format_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);
  a_pd_write_lands: assert property (reg_wr_in && reg_addr_in == `ADDR_REF_OSC_CTRL |->
    ##2 ref_osc_out_power_down_out == $past(reg_wdata_in[`BIT_REF_OSC_PD], 2))
    else $error("power down output does not follow its write");
  a_format_write_lands: assert property (reg_wr_in && reg_addr_in == `ADDR_REF_OSC_CTRL |->
    ##2 ref_osc_out_format_out == $past(reg_wdata_in[`BIT_REF_OSC_FORMAT], 2))
    else $error("format output does not follow its write");
  a_unmapped_reads_zero: assert property (reg_rd_in && reg_addr_in < `ADDR_DELAY_BASE |=>
    reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_polarity_reserved_zero: assert property (reg_rd_in && reg_addr_in == `ADDR_PIN_POLARITY |=>
    reg_rdata_out[7:1] == 7'h00) else $error("polarity reserved bits not zero");
  a_ctrl_reserved_zero: assert property (reg_rd_in && reg_addr_in == `ADDR_REF_OSC_CTRL |=>
    reg_rdata_out[7:2] == 6'h00) else $error("control reserved bits not zero");
  a_latch_reserved_zero: assert property (reg_rd_in && reg_addr_in == `ADDR_LATCHED_STATUS |=>
    reg_rdata_out[5:4] == 2'h0) else $error("latched reserved bits not zero");
  a_live_reserved_zero: assert property (reg_rd_in && reg_addr_in == `ADDR_LIVE_STATUS |=>
    reg_rdata_out[5:4] == 2'h0) else $error("live reserved bits not zero");
  a_delay_reserved_zero: assert property (reg_rd_in && reg_addr_in >= `ADDR_DELAY_BASE &&
    reg_addr_in < `ADDR_DELAY_BASE + `NUM_OUTPUTS |=> reg_rdata_out[7:6] == 2'h0)
    else $error("delay reserved bits not zero");
  c_ctrl_write: cover property (reg_wr_in && reg_addr_in == `ADDR_REF_OSC_CTRL);
  c_live_read: cover property (reg_rd_in && reg_addr_in == `ADDR_LIVE_STATUS);
  c_unmapped_read: cover property (reg_rd_in && reg_addr_in < `ADDR_DELAY_BASE);
endmodule // regs_checker

bind output_delay_and_status_regs regs_checker regs_checker_i (.core_clk_in(core_clk_in),
  .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .ref_osc_out_power_down_out(ref_osc_out_power_down_out),
  .ref_osc_out_format_out(ref_osc_out_format_out));

//--- verif/tb_top.sv
// self-checking bench for the status and delay register bank
`include "output_delay_and_status_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'h0, srst_in = 1'h1, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, lat;
  logic [5:0] mon = 6'h3d;
  logic [15:0] half_period_ps_in = 16'h0000;
  logic fcv = 1'h1, osc_init = 1'h1;
  logic [1:0] sel_ref = 2'h2;
  logic pd, fmt, lv;
  logic [1:0] pin, oe;
  logic [`NUM_OUTPUTS*`DELAY_WIDTH-1:0] dly;
  logic [7:0] cfg [`NUM_OUTPUTS];
  int n_errors = 0, checks = 0;
  output_delay_and_status_regs output_delay_and_status_regs_i (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .input0_loss_live_in(mon[5]), .input1_loss_live_in(mon[4]),
    .first_loop_lock_live_in(mon[3]), .second_loop_lock_live_in(mon[2]),
    .first_loop_holdover_live_in(mon[1]), .first_loop_ref_valid_live_in(mon[0]),
    .forced_control_voltage_status_in(fcv), .selected_reference_status_in(sel_ref),
    .internal_osc_init_status_in(osc_init), .half_period_ps_in(half_period_ps_in),
    .ref_osc_out_power_down_out(pd), .ref_osc_out_format_out(fmt),
    .status_pin_out(pin), .status_pin_oe_out(oe), .output_delay_ps_out(dly));
  initial begin
    forever #2 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'h0;
    #1 chk(reg_rdata_out, exp);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk_in);
    n_errors++;
    complete_run;
  end
  initial begin
    logic [18:0] e;
    e = 19'($urandom(74));
    repeat (5) @(posedge core_clk_in);
    srst_in <= 1'h0;
    settle(4);
    rdchk(`ADDR_PIN_FUNCTION, 8'hab);
    rdchk(`ADDR_PIN_POLARITY, 8'h00);
    rdchk(`ADDR_IRQ_ENABLE, 8'h00);
    rdchk(`ADDR_LATCHED_STATUS, 8'hcf);
    rdchk(`ADDR_LIVE_STATUS, 8'hcd);
    rdchk(`ADDR_FCV_REF_STATUS, 8'ha0);
    rdchk(`ADDR_OSC_INIT_STATUS, 8'h04);
    rdchk(`ADDR_REF_OSC_CTRL, 8'h00);
    rdchk(8'h00, 8'h00);
    $display("reset test done");
    wr(`ADDR_REF_OSC_CTRL, 8'hfd);
    rdchk(`ADDR_REF_OSC_CTRL, 8'h01);
    chk(pd, 1'h1);
    chk(fmt, 1'h0);
    wr(`ADDR_REF_OSC_CTRL, 8'h02);
    settle(2);
    chk({pd, fmt}, 2'h1);
    $display("oscillator output test done");
    @(posedge core_clk_in) half_period_ps_in <= 16'($urandom);
    for (int i = 0; i < `NUM_OUTPUTS; i++) begin
      cfg[i] = 8'($urandom);
      cfg[i][5] = i[0];
      wr(`ADDR_DELAY_BASE + 8'(i), cfg[i]);
      rdchk(`ADDR_DELAY_BASE + 8'(i), cfg[i] & 8'h3f);
    end
    settle(3);
    for (int i = 0; i < `NUM_OUTPUTS; i++) begin
      e = 19'(cfg[i][1:0]) * (cfg[i][5] ? 19'(half_period_ps_in) : 19'h00fe);
      chk(dly[19*i +: 19], e + 19'(cfg[i][4:2]) * 19'h001e);
    end
    $display("delay test done");
    @(posedge core_clk_in) mon <= 6'h1d;
    settle(4);
    @(posedge core_clk_in) mon <= 6'h3d;
    settle(4);
    rdchk(`ADDR_LATCHED_STATUS, 8'h4f);
    rdchk(`ADDR_LIVE_STATUS, 8'hcd);
    wr(`ADDR_PIN_FUNCTION, 8'had);
    settle(3);
    chk(pin, 2'h2);
    wr(`ADDR_IRQ_ENABLE, 8'hff);
    rdchk(`ADDR_IRQ_ENABLE, 8'hcf);
    settle(3);
    chk(pin, 2'h3);
    wr(`ADDR_PIN_POLARITY, 8'hff);
    rdchk(`ADDR_PIN_POLARITY, 8'h01);
    settle(3);
    chk(pin, 2'h0);
    wr(`ADDR_LATCHED_STATUS, 8'h80);
    settle(3);
    chk(pin, 2'h1);
    wr(`ADDR_PIN_POLARITY, 8'h00);
    wr(`ADDR_LATCHED_STATUS, 8'hff);
    lat = 8'hcf;
    for (int c = 8; c < 13; c++) begin
      @(posedge core_clk_in) mon <= 6'($urandom);
      wr(`ADDR_PIN_FUNCTION, {4'(c), 4'hd});
      settle(4);
      lat = lat & {mon[5:4], 2'h0, mon[3:2], ~mon[1], mon[0]};
      case (c)
        8: lv = mon[3];
        9: lv = mon[2];
        10: lv = mon[3] & mon[2];
        11: lv = ~mon[5] | ~mon[4];
        default: lv = mon[1];
      endcase
      chk({oe, pin}, {2'h3, lv, |(~lat & 8'hcf)});
      rdchk(`ADDR_LATCHED_STATUS, lat);
    end
    $display("status pin test done");
    @(posedge core_clk_in);
    mon <= 6'h3d;
    srst_in <= 1'h1;
    repeat (5) @(posedge core_clk_in);
    srst_in <= 1'h0;
    settle(4);
    rdchk(`ADDR_LATCHED_STATUS, 8'hcf);
    rdchk(`ADDR_PIN_FUNCTION, 8'hab);
    rdchk(`ADDR_REF_OSC_CTRL, 8'h00);
    chk({pd, fmt}, 2'h0);
    $display("mid-run reset test done");
    @(posedge core_clk_in);
    sel_ref <= 2'($urandom);
    fcv <= 1'($urandom);
    osc_init <= 1'($urandom);
    wr(`ADDR_PIN_FUNCTION, 8'h7f);
    settle(4);
    chk({oe, pin}, {2'h1, 1'h0, sel_ref[0]});
    rdchk(`ADDR_FCV_REF_STATUS, {fcv, 1'h0, sel_ref, 4'h0});
    rdchk(`ADDR_OSC_INIT_STATUS, {5'h00, osc_init, 2'h0});
    wr(`ADDR_PIN_FUNCTION, 8'hf1);
    settle(3);
    chk({oe, pin}, 4'h0);
    $display("pin code and status test done");
    complete_run;
  end
endmodule // tb_top
